/* File: logic/dtb_params.svh */
/*
 * Constants for the drive tuning and backup access register bank:
 * register indices, network command codes, key values, parameter limits
 * and initial values, ramp timing.
 * Assumes the includer compiles it once per unit; guard prevents repeats.
 */
// Functional notes
// - Loop gains and integral time act only in load-adaptive current mode.
// - Position loop gain accepts 1..50, initial 10.
// - Speed loop gain accepts 10..200, initial 180.
// - Speed integral time accepts 100..2000 (0.1 ms units), initial 1000.
// - Operating current target changes ramp at configured rate.
// - Standstill cutback current changes bypass the ramp.
// - Ramp-up rate 0..100 ms per full scale, initial 0, rising only.
// - Ramp-down rate 0..100 ms per full scale, initial 0, falling only.
// - Deviation acceleration suppression gain accepts 0..500, initial 45.
// - Nonvolatile backup area holds full set; restore returns stored data.
// - Access key register RW, initial zero, at 0040h/0041h, codes 0020h/1020h.
// - Write key register RW, initial zero, at 0042h/0043h, codes 0021h/1021h.
// - Write to backup read command restores whole backup area.
// - Write to backup store command saves whole data set to backup.
// - Store needs access key 01391955h and write key 75DB9C97h.
// - Restore needs access key only.
// - Adaptive mode varies current with load; constant mode holds current.
`ifndef DTB_PARAMS_SVH
`define DTB_PARAMS_SVH

`define DTB_REG_ACCESS_KEY 16'h0040
`define DTB_REG_WRITE_KEY 16'h0042
`define DTB_REG_READ_CMD 16'h0196
`define DTB_REG_STORE_CMD 16'h0198
`define DTB_REG_POS_GAIN 16'h0200
`define DTB_REG_SPD_GAIN 16'h0202
`define DTB_REG_INT_TIME 16'h0204
`define DTB_REG_RAMP_UP 16'h0206
`define DTB_REG_RAMP_DOWN 16'h0208
`define DTB_REG_SUPP_GAIN 16'h020A

`define DTB_NET_RD_ACCESS 16'h0020
`define DTB_NET_RD_WRITE 16'h0021
`define DTB_NET_WR_ACCESS 16'h1020
`define DTB_NET_WR_WRITE 16'h1021
`define DTB_NET_WR_READ 16'h30CB
`define DTB_NET_WR_STORE 16'h30CC

`define DTB_ACCESS_KEY 32'h0139_1955
`define DTB_WRITE_KEY 32'h75DB_9C97

`define DTB_POS_MIN 32'h0000_0001
`define DTB_POS_MAX 32'h0000_0032
`define DTB_POS_INIT 32'h0000_000A
`define DTB_SPD_MIN 32'h0000_000A
`define DTB_SPD_MAX 32'h0000_00C8
`define DTB_SPD_INIT 32'h0000_00B4
`define DTB_INT_MIN 32'h0000_0064
`define DTB_INT_MAX 32'h0000_07D0
`define DTB_INT_INIT 32'h0000_03E8
`define DTB_RAMP_MAX 32'h0000_0064
`define DTB_RAMP_INIT 32'h0000_0000
`define DTB_SUPP_MAX 32'h0000_01F4
`define DTB_SUPP_INIT 32'h0000_002D

// Ramp: 1 ms per unit of rate spread over full scale
`define DTB_CLK_HZ 10000000
`define DTB_MS_NS 1000000
`define DTB_CLK_NS 100
`define DTB_CYC_PER_MS (`DTB_MS_NS / `DTB_CLK_NS)

`endif

/* File: logic/dtb_pkg.sv */
/*
 * Types for the drive tuning and backup access block.
 * Assumes dtb_params.svh supplies the numeric constants.
 */
`default_nettype none
package dtb_pkg;
	typedef enum logic [1:0] {
		DTB_OP_IDLE,
		DTB_OP_STORE,
		DTB_OP_RESTORE
	} dtb_op_t;

	typedef enum logic {
		DTB_MODE_CONSTANT,
		DTB_MODE_ADAPTIVE
	} dtb_mode_t;
endpackage : dtb_pkg
`default_nettype wire

/* File: logic/dtb_bank.sv */
/*
 * Tuning and backup register bank of a stepping motor driver.
 * Serial 16-bit register port (upper half at even address) and a
 * network command port with 32-bit data. Backup area is a local array
 * standing for nonvolatile storage; contents survive RST.
 * Assumes inputs synchronous to SYS_CLK, one access per cycle.
 */
`include "dtb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dtb_bank #(
	parameter int CUR_W = 10,
	parameter int SET_WORDS = 6
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic SER_WR,
	input wire logic SER_RD,
	input wire logic [15:0] SER_ADDR,
	input wire logic [15:0] SER_WDATA,
	output logic [15:0] SER_RDATA,
	output logic SER_ACK,
	input wire logic NET_CMD_VALID,
	input wire logic [15:0] NET_CMD_CODE,
	input wire logic [31:0] NET_WDATA,
	output logic [31:0] NET_RDATA,
	output logic NET_ACK,
	input wire logic LOAD_ADAPTIVE_MODE,
	input wire logic [CUR_W-1:0] OP_CURRENT_TARGET,
	input wire logic [CUR_W-1:0] STOP_CURRENT,
	input wire logic STANDSTILL_CUTBACK,
	output logic [CUR_W-1:0] CURRENT_SETPOINT,
	output logic [31:0] POS_GAIN_OUT,
	output logic [31:0] SPD_GAIN_OUT,
	output logic [31:0] INT_TIME_OUT,
	output logic [31:0] SUPP_GAIN_OUT,
	output logic LOOP_ACTIVE,
	output logic BACKUP_DONE,
	output logic BACKUP_REFUSED
);
	// Ramp arithmetic and the backup word map need these limits
	if (CUR_W < 2 || CUR_W > 16 || SET_WORDS != 6) begin : g_bad_params
		$error("dtb_bank: unsupported parameters");
	end

	////////////////////////////////////////////////////////////////////
	// Register storage
	logic [31:0] access_key;
	logic [31:0] write_key;
	logic [31:0] pos_gain;
	logic [31:0] spd_gain;
	logic [31:0] int_time;
	logic [31:0] ramp_up;
	logic [31:0] ramp_down;
	logic [31:0] supp_gain;
	// Survives reset: stands in for nonvolatile memory
	logic [31:0] backup_area [SET_WORDS];
	logic [15:0] upper_hold;

	logic [15:0] ser_base;
	logic ser_low;
	logic [31:0] ser_word;
	logic ser_commit;
	logic [15:0] eff_addr;
	logic eff_wr;
	logic [31:0] eff_data;
	logic key_ok_read;
	logic key_ok_store;
	logic [31:0] cur_set [SET_WORDS];
	logic [31:0] ser_rd_word;
	logic cutback_q;
	logic loop_on;
	dtb_pkg::dtb_op_t op;
	dtb_pkg::dtb_mode_t mode;

	assign ser_low = SER_ADDR[0];
	assign ser_base = {SER_ADDR[15:1], 1'b0};
	assign ser_word = {upper_hold, SER_WDATA};
	assign ser_commit = SER_WR && ser_low;

	// Network write codes mapped onto serial base addresses
	always_comb begin
		eff_wr = 1'b0;
		eff_addr = 16'h0000;
		eff_data = NET_WDATA;
		if (NET_CMD_VALID) begin
			eff_wr = 1'b1;
			unique case (NET_CMD_CODE)
				`DTB_NET_WR_ACCESS: eff_addr = `DTB_REG_ACCESS_KEY;
				`DTB_NET_WR_WRITE: eff_addr = `DTB_REG_WRITE_KEY;
				`DTB_NET_WR_READ: eff_addr = `DTB_REG_READ_CMD;
				`DTB_NET_WR_STORE: eff_addr = `DTB_REG_STORE_CMD;
				default: eff_wr = 1'b0;
			endcase
		end else if (ser_commit) begin
			eff_wr = 1'b1;
			eff_addr = ser_base;
			eff_data = ser_word;
		end
	end

	// Backup command decode shared by restore, store and status
	always_comb begin
		op = dtb_pkg::DTB_OP_IDLE;
		if (eff_wr && eff_addr == `DTB_REG_STORE_CMD)
			op = dtb_pkg::DTB_OP_STORE;
		else if (eff_wr && eff_addr == `DTB_REG_READ_CMD)
			op = dtb_pkg::DTB_OP_RESTORE;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			upper_hold <= 16'h0000;
		else if (SER_WR && !ser_low)
			upper_hold <= SER_WDATA;
	end

	// Out-of-range values are refused and the old value kept
	function automatic logic in_range(input logic [31:0] v,
			input logic [31:0] lo, input logic [31:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	////////////////////////////////////////////////////////////////////
	// Keys
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			access_key <= 32'h0000_0000;
			write_key <= 32'h0000_0000;
		end else if (eff_wr) begin
			if (eff_addr == `DTB_REG_ACCESS_KEY)
				access_key <= eff_data;
			if (eff_addr == `DTB_REG_WRITE_KEY)
				write_key <= eff_data;
		end
	end

	assign key_ok_store = (access_key == `DTB_ACCESS_KEY) &&
		(write_key == `DTB_WRITE_KEY);
	assign key_ok_read = (access_key == `DTB_ACCESS_KEY);

	////////////////////////////////////////////////////////////////////
	// Tuning parameters
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pos_gain <= `DTB_POS_INIT;
			spd_gain <= `DTB_SPD_INIT;
			int_time <= `DTB_INT_INIT;
			ramp_up <= `DTB_RAMP_INIT;
			ramp_down <= `DTB_RAMP_INIT;
			supp_gain <= `DTB_SUPP_INIT;
		end else if (op == dtb_pkg::DTB_OP_RESTORE && key_ok_read) begin
			pos_gain <= backup_area[0];
			spd_gain <= backup_area[1];
			int_time <= backup_area[2];
			ramp_up <= backup_area[3];
			ramp_down <= backup_area[4];
			supp_gain <= backup_area[5];
		end else if (eff_wr) begin
			if (eff_addr == `DTB_REG_POS_GAIN &&
					in_range(eff_data, `DTB_POS_MIN, `DTB_POS_MAX))
				pos_gain <= eff_data;
			if (eff_addr == `DTB_REG_SPD_GAIN &&
					in_range(eff_data, `DTB_SPD_MIN, `DTB_SPD_MAX))
				spd_gain <= eff_data;
			if (eff_addr == `DTB_REG_INT_TIME &&
					in_range(eff_data, `DTB_INT_MIN, `DTB_INT_MAX))
				int_time <= eff_data;
			if (eff_addr == `DTB_REG_RAMP_UP && eff_data <= `DTB_RAMP_MAX)
				ramp_up <= eff_data;
			if (eff_addr == `DTB_REG_RAMP_DOWN &&
					eff_data <= `DTB_RAMP_MAX)
				ramp_down <= eff_data;
			if (eff_addr == `DTB_REG_SUPP_GAIN &&
					eff_data <= `DTB_SUPP_MAX)
				supp_gain <= eff_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Backup area
	assign cur_set[0] = pos_gain;
	assign cur_set[1] = spd_gain;
	assign cur_set[2] = int_time;
	assign cur_set[3] = ramp_up;
	assign cur_set[4] = ramp_down;
	assign cur_set[5] = supp_gain;

	genvar gi;
	generate
		for (gi = 0; gi < SET_WORDS; gi++) begin : g_backup
			always_ff @(posedge SYS_CLK) begin
				if (op == dtb_pkg::DTB_OP_STORE && key_ok_store)
					backup_area[gi] <= cur_set[gi];
			end
		end
	endgenerate

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			BACKUP_DONE <= 1'b0;
			BACKUP_REFUSED <= 1'b0;
		end else begin
			BACKUP_DONE <= 1'b0;
			BACKUP_REFUSED <= 1'b0;
			unique case (op)
				dtb_pkg::DTB_OP_STORE: begin
					BACKUP_DONE <= key_ok_store;
					BACKUP_REFUSED <= !key_ok_store;
				end
				dtb_pkg::DTB_OP_RESTORE: begin
					BACKUP_DONE <= key_ok_read;
					BACKUP_REFUSED <= !key_ok_read;
				end
				dtb_pkg::DTB_OP_IDLE: begin
					// Both pulses stay low
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read paths
	function automatic logic [31:0] reg_value(input logic [15:0] a);
		unique case (a)
			`DTB_REG_ACCESS_KEY: reg_value = access_key;
			`DTB_REG_WRITE_KEY: reg_value = write_key;
			`DTB_REG_POS_GAIN: reg_value = pos_gain;
			`DTB_REG_SPD_GAIN: reg_value = spd_gain;
			`DTB_REG_INT_TIME: reg_value = int_time;
			`DTB_REG_RAMP_UP: reg_value = ramp_up;
			`DTB_REG_RAMP_DOWN: reg_value = ramp_down;
			`DTB_REG_SUPP_GAIN: reg_value = supp_gain;
			// Write-only and unmapped read as zero
			default: reg_value = 32'h0000_0000;
		endcase
	endfunction : reg_value

	// Function reads registers, so it needs a combinational process
	always_comb ser_rd_word = reg_value(ser_base);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SER_RDATA <= 16'h0000;
			SER_ACK <= 1'b0;
		end else begin
			SER_ACK <= SER_RD || SER_WR;
			if (SER_RD)
				SER_RDATA <= ser_low ? ser_rd_word[15:0] :
					ser_rd_word[31:16];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			NET_RDATA <= 32'h0000_0000;
			NET_ACK <= 1'b0;
		end else begin
			NET_ACK <= NET_CMD_VALID;
			if (NET_CMD_VALID) begin
				unique case (NET_CMD_CODE)
					`DTB_NET_RD_ACCESS: NET_RDATA <= access_key;
					`DTB_NET_RD_WRITE: NET_RDATA <= write_key;
					default: NET_RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Loop parameter outputs
	assign mode = LOAD_ADAPTIVE_MODE ? dtb_pkg::DTB_MODE_ADAPTIVE :
		dtb_pkg::DTB_MODE_CONSTANT;
	assign loop_on = (mode == dtb_pkg::DTB_MODE_ADAPTIVE);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			POS_GAIN_OUT <= 32'h0000_0000;
			SPD_GAIN_OUT <= 32'h0000_0000;
			INT_TIME_OUT <= 32'h0000_0000;
			LOOP_ACTIVE <= 1'b0;
			SUPP_GAIN_OUT <= `DTB_SUPP_INIT;
		end else begin
			LOOP_ACTIVE <= loop_on;
			POS_GAIN_OUT <= loop_on ? pos_gain : 32'h0000_0000;
			SPD_GAIN_OUT <= loop_on ? spd_gain : 32'h0000_0000;
			INT_TIME_OUT <= loop_on ? int_time : 32'h0000_0000;
			SUPP_GAIN_OUT <= supp_gain;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Current ramp: one step per (rate ms * cycles/ms) / full scale
	localparam logic [CUR_W-1:0] CUR_FULL = '1;
	logic [31:0] step_cnt;
	logic [31:0] step_len;
	logic [CUR_W-1:0] goal;
	logic rising;

	// Cutback target during cutback, operating current target otherwise; no limit applied
	assign goal = STANDSTILL_CUTBACK ? STOP_CURRENT : OP_CURRENT_TARGET;
	assign rising = goal > CURRENT_SETPOINT;
	// Up rate for rising, down rate for falling
	assign step_len = 32'((rising ? ramp_up : ramp_down) *
		`DTB_CYC_PER_MS / 32'(CUR_FULL));

	// Remembers cutback so its release skips the ramp as well
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			cutback_q <= 1'b0;
		else
			cutback_q <= STANDSTILL_CUTBACK;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			CURRENT_SETPOINT <= '0;
			step_cnt <= 32'h0000_0000;
		end else if (STANDSTILL_CUTBACK) begin
			CURRENT_SETPOINT <= STOP_CURRENT;
			step_cnt <= 32'h0000_0000;
		end else if (cutback_q) begin
			// Return from cutback skips ramp too
			CURRENT_SETPOINT <= OP_CURRENT_TARGET;
			step_cnt <= 32'h0000_0000;
		end else if (goal == CURRENT_SETPOINT) begin
			step_cnt <= 32'h0000_0000;
		end else if (step_len == 32'h0000_0000) begin
			CURRENT_SETPOINT <= goal;
		end else if (step_cnt + 32'h0000_0001 >= step_len) begin
			step_cnt <= 32'h0000_0000;
			CURRENT_SETPOINT <= rising ? CURRENT_SETPOINT + 1'b1 :
				CURRENT_SETPOINT - 1'b1;
		end else begin
			step_cnt <= step_cnt + 32'h0000_0001;
		end
	end
endmodule : dtb_bank
`default_nettype wire

/* File: tb/dtb_bank_assertions.sv */
/*
 * Port checker for the tuning and backup register bank.
 * Assumes binding to every dtb_bank instance; sees ports only.
 */
`include "dtb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dtb_chk #(
	parameter int CUR_W = 10
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic SER_WR,
	input wire logic SER_RD,
	input wire logic SER_ACK,
	input wire logic NET_CMD_VALID,
	input wire logic NET_ACK,
	input wire logic LOAD_ADAPTIVE_MODE,
	input wire logic LOOP_ACTIVE,
	input wire logic [CUR_W-1:0] OP_CURRENT_TARGET,
	input wire logic [CUR_W-1:0] STOP_CURRENT,
	input wire logic STANDSTILL_CUTBACK,
	input wire logic [CUR_W-1:0] CURRENT_SETPOINT,
	input wire logic [31:0] POS_GAIN_OUT,
	input wire logic [31:0] SPD_GAIN_OUT,
	input wire logic [31:0] INT_TIME_OUT,
	input wire logic [31:0] SUPP_GAIN_OUT,
	input wire logic BACKUP_DONE,
	input wire logic BACKUP_REFUSED
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////////////
	a_ser_ack_cause: assert property (
		SER_ACK |-> $past(SER_WR || SER_RD))
		else $error("serial ack without request");
	a_net_ack_due: assert property (
		NET_CMD_VALID |=> NET_ACK)
		else $error("network ack missing");
	a_done_exclusive: assert property (
		!(BACKUP_DONE && BACKUP_REFUSED))
		else $error("backup done and refused together");
	a_done_cause: assert property (
		(BACKUP_DONE || BACKUP_REFUSED) |->
		$past(NET_CMD_VALID || SER_WR))
		else $error("backup result without command");
	a_loop_follow: assert property (
		!$past(RST) |-> LOOP_ACTIVE == $past(LOAD_ADAPTIVE_MODE))
		else $error("loop active not tracking mode");
	a_const_gain_zero: assert property (
		(!LOAD_ADAPTIVE_MODE)[*2] |-> POS_GAIN_OUT == 0 &&
		SPD_GAIN_OUT == 0 && INT_TIME_OUT == 0)
		else $error("loop gains driven in constant mode");
	a_gain_ranges: assert property (
		LOAD_ADAPTIVE_MODE[*2] |->
		POS_GAIN_OUT inside {[`DTB_POS_MIN:`DTB_POS_MAX]} &&
		SPD_GAIN_OUT inside {[`DTB_SPD_MIN:`DTB_SPD_MAX]} &&
		INT_TIME_OUT inside {[`DTB_INT_MIN:`DTB_INT_MAX]})
		else $error("loop gain out of range");
	a_supp_range: assert property (
		SUPP_GAIN_OUT <= `DTB_SUPP_MAX)
		else $error("suppression gain out of range");
	a_cutback_direct: assert property (
		(!LOAD_ADAPTIVE_MODE && STANDSTILL_CUTBACK &&
		$stable(STOP_CURRENT))[*2] |-> CURRENT_SETPOINT == STOP_CURRENT)
		else $error("cutback current was ramped");
	a_ramp_monotone: assert property (
		!STANDSTILL_CUTBACK && $stable(OP_CURRENT_TARGET) &&
		CURRENT_SETPOINT <= OP_CURRENT_TARGET |=>
		CURRENT_SETPOINT <= $past(OP_CURRENT_TARGET) &&
		CURRENT_SETPOINT >= $past(CURRENT_SETPOINT))
		else $error("ramp moved away from target");
	c_done: cover property (BACKUP_DONE);
	c_refused: cover property (BACKUP_REFUSED);
	c_cutback: cover property (STANDSTILL_CUTBACK && CURRENT_SETPOINT == STOP_CURRENT);
endmodule : dtb_chk
bind dtb_bank dtb_chk #(.CUR_W(CUR_W)) u_chk (.SYS_CLK(SYS_CLK), .RST(RST),
	.SER_WR(SER_WR), .SER_RD(SER_RD), .SER_ACK(SER_ACK),
	.NET_CMD_VALID(NET_CMD_VALID), .NET_ACK(NET_ACK),
	.LOAD_ADAPTIVE_MODE(LOAD_ADAPTIVE_MODE), .LOOP_ACTIVE(LOOP_ACTIVE),
	.OP_CURRENT_TARGET(OP_CURRENT_TARGET), .STOP_CURRENT(STOP_CURRENT),
	.STANDSTILL_CUTBACK(STANDSTILL_CUTBACK),
	.CURRENT_SETPOINT(CURRENT_SETPOINT), .POS_GAIN_OUT(POS_GAIN_OUT),
	.SPD_GAIN_OUT(SPD_GAIN_OUT), .INT_TIME_OUT(INT_TIME_OUT),
	.SUPP_GAIN_OUT(SUPP_GAIN_OUT), .BACKUP_DONE(BACKUP_DONE),
	.BACKUP_REFUSED(BACKUP_REFUSED));
`default_nettype wire

/* File: tb/dtb_host.sv */
/*
 * Host model: serial 16-bit register master and network command master.
 * Assumes the bank acks each request; drives at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module dtb_host (
	input wire logic sys_clk,
	output logic ser_wr,
	output logic ser_rd,
	output logic [15:0] ser_addr,
	output logic [15:0] ser_wdata,
	input wire logic [15:0] ser_rdata,
	input wire logic ser_ack,
	output logic net_valid,
	output logic [15:0] net_code,
	output logic [31:0] net_wdata,
	input wire logic [31:0] net_rdata,
	input wire logic net_ack,
	input wire logic done_in,
	input wire logic refused_in
);
	logic [31:0] rdata;
	logic done;
	logic refd;
	int misses = 0;
	initial begin
		{ser_wr, ser_rd, net_valid} = 3'h0;
		{ser_addr, ser_wdata, net_code} = 48'h0;
		net_wdata = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic half(input logic wr, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		@(negedge sys_clk);
		ser_wr = wr;
		ser_rd = !wr;
		ser_addr = a;
		ser_wdata = d;
		@(negedge sys_clk);
		ser_wr = 1'b0;
		ser_rd = 1'b0;
		// Released bus shows junk, not stale data
		ser_wdata = ~d;
		for (n = 0; n < 4 && ser_ack !== 1'b1; n++) @(negedge sys_clk);
		if (ser_ack !== 1'b1)
			misses++;
		q = ser_rdata;
		done = done_in;
		refd = refused_in;
	endtask : half
	task automatic ser_wr32(input logic [15:0] a, input logic [31:0] v);
		logic [15:0] q;
		half(1'b1, a, v[31:16], q);
		half(1'b1, a + 16'h1, v[15:0], q);
	endtask : ser_wr32
	task automatic ser_rd32(input logic [15:0] a, output logic [31:0] v);
		half(1'b0, a, 16'h0, v[31:16]);
		half(1'b0, a + 16'h1, 16'h0, v[15:0]);
	endtask : ser_rd32
	task automatic net(input logic [15:0] c, input logic [31:0] d);
		int n;
		@(negedge sys_clk);
		net_valid = 1'b1;
		net_code = c;
		net_wdata = d;
		@(negedge sys_clk);
		net_valid = 1'b0;
		net_wdata = ~d;
		for (n = 0; n < 4 && net_ack !== 1'b1; n++) @(negedge sys_clk);
		if (net_ack !== 1'b1)
			misses++;
		rdata = net_rdata;
		done = done_in;
		refd = refused_in;
	endtask : net
endmodule : dtb_host
`default_nettype wire

/* File: tb/tb.sv */
/*
 * Self-checking bench for dtb_bank with a host model.
 * Assumes CUR_W of 4 so one ramp step takes 666 cycles.
 */
`include "dtb_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic sys_clk = 1'b0;
	logic rst, sw, sr, ack_s, nv, ack_n, mode, cut, loop_act, done, refd;
	logic [15:0] sa, sd, srd, nc;
	logic [31:0] nd, nrd, pos, spd, itm, supp, v;
	logic [3:0] tgt, stopc, setp;
	int err_count = 0;
	int cmp_count = 0;
	int n;
	always #50 sys_clk = ~sys_clk;
	dtb_host h (.sys_clk(sys_clk), .ser_wr(sw), .ser_rd(sr), .ser_addr(sa),
		.ser_wdata(sd), .ser_rdata(srd), .ser_ack(ack_s), .net_valid(nv),
		.net_code(nc), .net_wdata(nd), .net_rdata(nrd), .net_ack(ack_n),
		.done_in(done), .refused_in(refd));
	dtb_bank #(.CUR_W(4)) DUT (.SYS_CLK(sys_clk), .RST(rst), .SER_WR(sw),
		.SER_RD(sr), .SER_ADDR(sa), .SER_WDATA(sd), .SER_RDATA(srd),
		.SER_ACK(ack_s), .NET_CMD_VALID(nv), .NET_CMD_CODE(nc),
		.NET_WDATA(nd), .NET_RDATA(nrd), .NET_ACK(ack_n),
		.LOAD_ADAPTIVE_MODE(mode), .OP_CURRENT_TARGET(tgt),
		.STOP_CURRENT(stopc), .STANDSTILL_CUTBACK(cut),
		.CURRENT_SETPOINT(setp), .POS_GAIN_OUT(pos), .SPD_GAIN_OUT(spd),
		.INT_TIME_OUT(itm), .SUPP_GAIN_OUT(supp), .LOOP_ACTIVE(loop_act),
		.BACKUP_DONE(done), .BACKUP_REFUSED(refd));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial begin
		#5000000;
		err_count++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		mode = 1'b1;
		cut = 1'b0;
		tgt = 4'h0;
		stopc = 4'h0;
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		h.ser_rd32(`DTB_REG_ACCESS_KEY, v);
		chk("access key", 32'h0, v);
		h.net(`DTB_NET_RD_WRITE, 32'h0);
		chk("write key", 32'h0, h.rdata);
		chk("pos", `DTB_POS_INIT, pos);
		chk("spd", `DTB_SPD_INIT, spd);
		chk("int", `DTB_INT_INIT, itm);
		chk("supp", `DTB_SUPP_INIT, supp);
		// Values just past one limit of each gain must be dropped
		h.ser_wr32(`DTB_REG_POS_GAIN, `DTB_POS_MAX + 1);
		h.ser_wr32(`DTB_REG_SPD_GAIN, `DTB_SPD_MIN - 1);
		h.ser_wr32(`DTB_REG_INT_TIME, `DTB_INT_MAX + 1);
		h.ser_wr32(`DTB_REG_SUPP_GAIN, `DTB_SUPP_MAX + 1);
		chk("pos", `DTB_POS_INIT, pos);
		chk("spd", `DTB_SPD_INIT, spd);
		chk("int", `DTB_INT_INIT, itm);
		chk("supp", `DTB_SUPP_INIT, supp);
		h.ser_wr32(`DTB_REG_POS_GAIN, `DTB_POS_MAX);
		h.ser_wr32(`DTB_REG_SPD_GAIN, `DTB_SPD_MIN);
		h.ser_wr32(`DTB_REG_INT_TIME, `DTB_INT_MIN);
		h.ser_wr32(`DTB_REG_SUPP_GAIN, `DTB_SUPP_MAX);
		// Gain outputs trail the register write by one cycle
		@(negedge sys_clk);
		chk("pos", `DTB_POS_MAX, pos);
		chk("spd", `DTB_SPD_MIN, spd);
		chk("int", `DTB_INT_MIN, itm);
		chk("supp", `DTB_SUPP_MAX, supp);
		mode = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("const gains", 32'h0, pos | spd | itm);
		chk("loop active", 32'h0, {31'h0, loop_act});
		mode = 1'b1;
		h.net(`DTB_NET_WR_STORE, 32'h0);
		chk("store no keys", 32'h1, {31'h0, h.refd});
		// Keys are loaded one at a time, each followed by a store command
		h.ser_wr32(`DTB_REG_ACCESS_KEY, `DTB_ACCESS_KEY);
		h.net(`DTB_NET_RD_ACCESS, 32'h0);
		chk("access key", `DTB_ACCESS_KEY, h.rdata);
		h.ser_wr32(`DTB_REG_STORE_CMD, 32'h0);
		chk("store one key", 32'h1, {31'h0, h.refd});
		h.net(`DTB_NET_WR_WRITE, `DTB_WRITE_KEY);
		h.ser_rd32(`DTB_REG_WRITE_KEY, v);
		chk("write key", `DTB_WRITE_KEY, v);
		h.net(`DTB_NET_WR_STORE, 32'h0);
		chk("store", 32'h1, {31'h0, h.done});
		h.ser_wr32(`DTB_REG_POS_GAIN, 32'h0000_0014);
		@(negedge sys_clk);
		chk("pos", 32'h0000_0014, pos);
		h.net(`DTB_NET_WR_WRITE, 32'h0);
		h.ser_wr32(`DTB_REG_READ_CMD, 32'h0);
		chk("restore", 32'h1, {31'h0, h.done});
		repeat (2) @(negedge sys_clk);
		chk("pos restored", `DTB_POS_MAX, pos);
		h.ser_rd32(`DTB_REG_READ_CMD, v);
		chk("wo read", 32'h0, v);
		h.net(`DTB_NET_WR_ACCESS, 32'h0);
		h.net(`DTB_NET_WR_READ, 32'h0);
		chk("restore no key", 32'h1, {31'h0, h.refd});
		mode = 1'b0;
		tgt = 4'h5;
		repeat (2) @(negedge sys_clk);
		chk("rate zero", 32'h5, {28'h0, setp});
		h.ser_wr32(`DTB_REG_RAMP_UP, 32'h1);
		tgt = 4'h9;
		repeat (10) @(negedge sys_clk);
		chk("ramp slow", 32'h1, {31'h0, setp < 4'h9});
		for (n = 0; n < 3000 && setp !== 4'h9; n++) @(negedge sys_clk);
		chk("ramp end", 32'h9, {28'h0, setp});
		tgt = 4'h2;
		repeat (2) @(negedge sys_clk);
		chk("fall", 32'h2, {28'h0, setp});
		stopc = 4'hC;
		cut = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("cutback", 32'hC, {28'h0, setp});
		// Rising return with ramp-up rate set must still be immediate
		tgt = 4'hE;
		cut = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("cut release", 32'hE, {28'h0, setp});
		chk("missing acks", 32'h0, h.misses);
		summarize();
	end
endmodule : tb
`default_nettype wire
